// [logic/pacm_pkg.sv]
package pacm_pkg;
   // register map
   localparam logic [8:0] HOST_LINK_AND_IRQ_CONFIG_OFFSET   = 9'h143;
   localparam logic [8:0] RAIL_MONITOR_MASKING_CONFIG_OFFSET = 9'h144;
   localparam logic [7:0] HOST_LINK_AND_IRQ_CONFIG_RESET    = 8'h12;
   localparam logic [7:0] RAIL_MONITOR_MASKING_CONFIG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE               = 8'h00;

   // host_link_and_irq_config fields
   localparam int LINK_TIMEOUT_ENABLE_BIT = 4;
   localparam int GPI_SUPPLY_SELECT_BIT   = 3;
   localparam int IRQ_OPEN_DRAIN_BIT      = 1;
   localparam int IRQ_ACTIVE_HIGH_BIT     = 0;

   // rail_monitor_masking_config fields
   localparam int IO_RAIL_LOCKOUT_DISABLE_BIT = 7;
   localparam int BUCK_B_POWER_GOOD_HOLD_BIT  = 6;
   localparam int BUCK_A_POWER_GOOD_HOLD_BIT  = 5;
   localparam int BUCK_B_OVERCURRENT_MASK_LSB = 3;
   localparam int BUCK_A_OVERCURRENT_MASK_LSB = 1;

   // over-current mask codes
   localparam logic [1:0] OC_MASK_NEVER = 2'h0;
   localparam logic [1:0] OC_MASK_2US   = 2'h1;
   localparam logic [1:0] OC_MASK_10US  = 2'h2;
   localparam logic [1:0] OC_MASK_50US  = 2'h3;

   // timing
   localparam int CLOCK_HZ          = 100_000_000;
   localparam int LINK_TIMEOUT_MS   = 35;
   localparam int OC_EXTRA_SHORT_US = 2;
   localparam int OC_EXTRA_MID_US   = 10;
   localparam int OC_EXTRA_LONG_US  = 50;
   localparam int LINK_TIMEOUT_CYCLES  = LINK_TIMEOUT_MS * (CLOCK_HZ / 1000);
   localparam int OC_EXTRA_SHORT_CYCLES = OC_EXTRA_SHORT_US * (CLOCK_HZ / 1_000_000);
   localparam int OC_EXTRA_MID_CYCLES   = OC_EXTRA_MID_US * (CLOCK_HZ / 1_000_000);
   localparam int OC_EXTRA_LONG_CYCLES  = OC_EXTRA_LONG_US * (CLOCK_HZ / 1_000_000);
   localparam int LINK_COUNT_WIDTH = 22;
   localparam int OC_COUNT_WIDTH   = 13;
endpackage : pacm_pkg

// [logic/pacm_buck_if.sv]
`timescale 1ns/1ps
interface pacm_buck_if;
   logic       transition;
   logic       pg_live;
   logic       oc_hit;
   logic       pg_hold_en;
   logic [1:0] oc_mask_code;
   logic       pg_out;
   logic       oc_event;

   modport ctrl (output transition, output pg_live, output oc_hit, output pg_hold_en,
                 output oc_mask_code, input pg_out, input oc_event);
   modport unit (input transition, input pg_live, input oc_hit, input pg_hold_en,
                 input oc_mask_code, output pg_out, output oc_event);
endinterface : pacm_buck_if

// [logic/pacm_buck_mask.sv]
`timescale 1ns/1ps
module pacm_buck_mask #(
   parameter int LONG_CYCLES = pacm_pkg::OC_EXTRA_LONG_CYCLES
) (
   // clock and reset
   input  wire logic  mclk,
   input  wire logic  rst_n,
   // buck signals
   pacm_buck_if.unit  bus
);
   logic [pacm_pkg::OC_COUNT_WIDTH-1:0] hold_count;
   logic                                transition_d;
   logic                                oc_hit_d;
   logic                                oc_masked;

   function automatic logic [pacm_pkg::OC_COUNT_WIDTH-1:0] extra_cycles(input logic [1:0] code);
      case (code)
         pacm_pkg::OC_MASK_2US:  extra_cycles = pacm_pkg::OC_COUNT_WIDTH'(pacm_pkg::OC_EXTRA_SHORT_CYCLES);
         pacm_pkg::OC_MASK_10US: extra_cycles = pacm_pkg::OC_COUNT_WIDTH'(pacm_pkg::OC_EXTRA_MID_CYCLES);
         pacm_pkg::OC_MASK_50US: extra_cycles = pacm_pkg::OC_COUNT_WIDTH'(LONG_CYCLES);
         default:                extra_cycles = '0;
      endcase
   endfunction : extra_cycles

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         transition_d <= 1'b0;
         oc_hit_d     <= 1'b0;
      end else begin
         transition_d <= bus.transition;
         oc_hit_d     <= bus.oc_hit;
      end
   end

   // extra masking interval starts when the transition ends
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hold_count <= '0;
      end else if (bus.transition) begin
         hold_count <= '0;
      end else if (transition_d && bus.oc_mask_code != pacm_pkg::OC_MASK_NEVER) begin
         hold_count <= extra_cycles(bus.oc_mask_code);
      end else if (hold_count != '0) begin
         hold_count <= hold_count - 1'b1;
      end
   end

   // code change to never-mask releases immediately; transition_d covers the load cycle
   assign oc_masked = (bus.oc_mask_code != pacm_pkg::OC_MASK_NEVER) &&
                      (bus.transition || transition_d || hold_count != '0);

   // one event per rising edge of the hit, unless masked
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bus.oc_event <= 1'b0;
      end else begin
         bus.oc_event <= bus.oc_hit && !oc_hit_d && !oc_masked;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bus.pg_out <= 1'b0;
      end else if (!(bus.pg_hold_en && bus.transition)) begin
         bus.pg_out <= bus.pg_live;
      end
   end
endmodule : pacm_buck_mask

// [logic/pacm_app_config.sv]
`timescale 1ns/1ps
module pacm_app_config #(
   parameter int LINK_TIMEOUT_CYCLES = pacm_pkg::LINK_TIMEOUT_CYCLES,
   parameter int OC_LONG_CYCLES      = pacm_pkg::OC_EXTRA_LONG_CYCLES
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // register port from the serial interface logic
   input  wire logic [8:0]  reg_addr,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // link timeout
   input  wire logic        scl_pin,
   output logic             link_reset,
   // interrupt output pin
   input  wire logic        irq_request,
   output logic             interrupt_output_out,
   output logic             interrupt_output_oe,
   // io supply rail lockout
   input  wire logic        io_uvlo_raw,
   output logic             io_comparator_enable,
   output logic             io_rail_lockout,
   // gpi supply selection
   output logic             gpi_supply_select,
   // buck A
   input  wire logic        buck_a_transition,
   input  wire logic        buck_a_pg_raw,
   input  wire logic        buck_a_oc_raw,
   output logic             buck_a_power_good,
   output logic             buck_a_oc_event,
   // buck B
   input  wire logic        buck_b_transition,
   input  wire logic        buck_b_pg_raw,
   input  wire logic        buck_b_oc_raw,
   output logic             buck_b_power_good,
   output logic             buck_b_oc_event
);
   logic [7:0]                            host_link_and_irq_config;
   logic [7:0]                            rail_monitor_masking_config;
   logic [pacm_pkg::LINK_COUNT_WIDTH-1:0] low_count;
   logic [1:0]                            scl_sync;
   logic [1:0]                            uvlo_sync;
   logic [1:0]                            pg_a_sync;
   logic [1:0]                            pg_b_sync;
   logic [1:0]                            oc_a_sync;
   logic [1:0]                            oc_b_sync;
   logic                                  irq_active_high;
   logic                                  irq_open_drain;
   logic                                  lockout_disable;
   logic [1:0]                            reg_sel;

   pacm_buck_if buck_a ();
   pacm_buck_if buck_b ();

   // one-hot select of the mapped registers; other addresses select none
   function automatic logic [1:0] reg_select(input logic [8:0] addr);
      logic [1:0] sel;
      sel = 2'h0;
      if (addr == pacm_pkg::HOST_LINK_AND_IRQ_CONFIG_OFFSET) begin
         sel[0] = 1'b1;
      end
      if (addr == pacm_pkg::RAIL_MONITOR_MASKING_CONFIG_OFFSET) begin
         sel[1] = 1'b1;
      end
      return sel;
   endfunction : reg_select

   assign reg_sel = reg_select(reg_addr);

   // register writes
   // reserved bits are stored, so a read returns what was written
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         host_link_and_irq_config    <= pacm_pkg::HOST_LINK_AND_IRQ_CONFIG_RESET;
         rail_monitor_masking_config <= pacm_pkg::RAIL_MONITOR_MASKING_CONFIG_RESET;
      end else if (reg_write) begin
         if (reg_sel[0]) begin
            host_link_and_irq_config <= reg_wdata;
         end
         if (reg_sel[1]) begin
            rail_monitor_masking_config <= reg_wdata;
         end
      end
   end

   // read data is registered; unmapped addresses answer zero
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= pacm_pkg::UNMAPPED_READ_VALUE;
      end else if (reg_read) begin
         case (reg_sel)
            2'h1:    reg_rdata <= host_link_and_irq_config;
            2'h2:    reg_rdata <= rail_monitor_masking_config;
            default: reg_rdata <= pacm_pkg::UNMAPPED_READ_VALUE;
         endcase
      end
   end

   // pins and analogue comparators are asynchronous to mclk
   // scl resets high, its idle level, so no low time is counted at release
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         scl_sync  <= 2'h3;
         uvlo_sync <= 2'h0;
         pg_a_sync <= 2'h0;
         pg_b_sync <= 2'h0;
         oc_a_sync <= 2'h0;
         oc_b_sync <= 2'h0;
      end else begin
         scl_sync  <= {scl_sync[0], scl_pin};
         uvlo_sync <= {uvlo_sync[0], io_uvlo_raw};
         pg_a_sync <= {pg_a_sync[0], buck_a_pg_raw};
         pg_b_sync <= {pg_b_sync[0], buck_b_pg_raw};
         oc_a_sync <= {oc_a_sync[0], buck_a_oc_raw};
         oc_b_sync <= {oc_b_sync[0], buck_b_oc_raw};
      end
   end

   // counter saturates so one stuck-low period gives one reset pulse
   // clearing the enable clears the count, so re-enabling starts afresh
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         low_count  <= '0;
         link_reset <= 1'b0;
      end else if (scl_sync[1] || !host_link_and_irq_config[pacm_pkg::LINK_TIMEOUT_ENABLE_BIT]) begin
         low_count  <= '0;
         link_reset <= 1'b0;
      end else if (low_count < pacm_pkg::LINK_COUNT_WIDTH'(LINK_TIMEOUT_CYCLES)) begin
         low_count  <= low_count + 1'b1;
         link_reset <= 1'b0;
      end else begin
         link_reset <= (low_count == pacm_pkg::LINK_COUNT_WIDTH'(LINK_TIMEOUT_CYCLES));
         low_count  <= pacm_pkg::LINK_COUNT_WIDTH'(LINK_TIMEOUT_CYCLES) + 1'b1;
      end
   end

   // interrupt pin
   assign irq_active_high = host_link_and_irq_config[pacm_pkg::IRQ_ACTIVE_HIGH_BIT];
   assign irq_open_drain  = host_link_and_irq_config[pacm_pkg::IRQ_OPEN_DRAIN_BIT];

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         interrupt_output_out <= 1'b0;
         interrupt_output_oe  <= 1'b0;
      end else if (irq_open_drain) begin
         // drive only the asserted level, release otherwise
         interrupt_output_out <= irq_active_high;
         interrupt_output_oe  <= irq_request;
      end else begin
         interrupt_output_out <= irq_request ~^ irq_active_high;
         interrupt_output_oe  <= 1'b1;
      end
   end

   // io rail lockout; disabling also saves comparator current
   assign lockout_disable = rail_monitor_masking_config[pacm_pkg::IO_RAIL_LOCKOUT_DISABLE_BIT];

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         io_comparator_enable <= 1'b0;
         io_rail_lockout      <= 1'b0;
      end else begin
         io_comparator_enable <= !lockout_disable;
         io_rail_lockout      <= uvlo_sync[1] && !lockout_disable;
      end
   end

   // gpi supply select only steers pads elsewhere; nothing here depends on it
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gpi_supply_select <= 1'b0;
      end else begin
         gpi_supply_select <= host_link_and_irq_config[pacm_pkg::GPI_SUPPLY_SELECT_BIT];
      end
   end

   // per-buck masking
   assign buck_a.transition   = buck_a_transition;
   assign buck_a.pg_live      = pg_a_sync[1];
   assign buck_a.oc_hit       = oc_a_sync[1];
   assign buck_a.pg_hold_en   = rail_monitor_masking_config[pacm_pkg::BUCK_A_POWER_GOOD_HOLD_BIT];
   assign buck_a.oc_mask_code = rail_monitor_masking_config[pacm_pkg::BUCK_A_OVERCURRENT_MASK_LSB +: 2];
   assign buck_b.transition   = buck_b_transition;
   assign buck_b.pg_live      = pg_b_sync[1];
   assign buck_b.oc_hit       = oc_b_sync[1];
   assign buck_b.pg_hold_en   = rail_monitor_masking_config[pacm_pkg::BUCK_B_POWER_GOOD_HOLD_BIT];
   assign buck_b.oc_mask_code = rail_monitor_masking_config[pacm_pkg::BUCK_B_OVERCURRENT_MASK_LSB +: 2];

   pacm_buck_mask #(
      .LONG_CYCLES (OC_LONG_CYCLES)
   ) u_buck_a (
      .mclk  (mclk),
      .rst_n (rst_n),
      .bus   (buck_a.unit)
   );

   pacm_buck_mask #(
      .LONG_CYCLES (OC_LONG_CYCLES)
   ) u_buck_b (
      .mclk  (mclk),
      .rst_n (rst_n),
      .bus   (buck_b.unit)
   );

   assign buck_a_power_good = buck_a.pg_out;
   assign buck_a_oc_event   = buck_a.oc_event;
   assign buck_b_power_good = buck_b.pg_out;
   assign buck_b_oc_event   = buck_b.oc_event;
endmodule : pacm_app_config

// [verification/pacm_host_model.sv]
`timescale 1ns/1ps
module pacm_host_model (
   // clock
   input  wire logic       mclk,
   // register port
   output logic      [8:0] reg_addr,
   output logic            reg_write,
   output logic            reg_read,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   // serial clock
   output logic            scl_pin
);
   initial begin
      reg_addr = 9'h000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_wdata = 8'h00;
      scl_pin = 1'b1;
   end
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge mclk);
      reg_write = 1'b0;
      // stale data is inverted so a late sample shows up
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge mclk);
      reg_read = 1'b0;
      d = reg_rdata;
   endtask : rd
   task automatic scl_low(input int n);
      @(negedge mclk);
      scl_pin = 1'b0;
      repeat (n) @(negedge mclk);
      scl_pin = 1'b1;
   endtask : scl_low
endmodule : pacm_host_model

// [verification/pacm_app_config_properties.sv]
`timescale 1ns/1ps
module pacm_app_config_properties #(
   parameter int LINK_TIMEOUT_CYCLES = 50
) (
   // clock and reset
   input wire logic       mclk,
   input wire logic       rst_n,
   // register port
   input wire logic [8:0] reg_addr,
   input wire logic       reg_write,
   input wire logic [7:0] reg_wdata,
   // link and pin
   input wire logic       scl_pin,
   input wire logic       link_reset,
   input wire logic       irq_request,
   input wire logic       interrupt_output_out,
   input wire logic       interrupt_output_oe,
   // rails and bucks
   input wire logic       io_comparator_enable,
   input wire logic       io_rail_lockout,
   input wire logic       buck_a_transition,
   input wire logic       buck_a_power_good,
   input wire logic       buck_a_oc_event,
   input wire logic       buck_b_transition,
   input wire logic       buck_b_power_good
);
   logic [7:0] cfg_a;
   logic [7:0] cfg_b;
   int         low_cnt;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // shadow copies, since the checker sees only the ports
   always_ff @(posedge mclk) begin
      if (!rst_n)
         cfg_a <= pacm_pkg::HOST_LINK_AND_IRQ_CONFIG_RESET;
      else if (reg_write && reg_addr == pacm_pkg::HOST_LINK_AND_IRQ_CONFIG_OFFSET)
         cfg_a <= reg_wdata;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n)
         cfg_b <= pacm_pkg::RAIL_MONITOR_MASKING_CONFIG_RESET;
      else if (reg_write && reg_addr == pacm_pkg::RAIL_MONITOR_MASKING_CONFIG_OFFSET)
         cfg_b <= reg_wdata;
   end
   // raw pin count, saturating: an upper bound on the synced low time
   always_ff @(posedge mclk) begin
      if (!rst_n || scl_pin)
         low_cnt <= 0;
      else if (low_cnt < LINK_TIMEOUT_CYCLES)
         low_cnt <= low_cnt + 1;
   end
   a_push_pull_pin: assert property ($past(rst_n) && !$past(cfg_a[1]) |-> interrupt_output_oe &&
      interrupt_output_out == ($past(irq_request) ~^ $past(cfg_a[0]))) else $error("push-pull pin wrong");
   a_open_drain_pin: assert property ($past(rst_n) && $past(cfg_a[1]) |->
      interrupt_output_oe == $past(irq_request) && interrupt_output_out == $past(cfg_a[0])) else $error("open-drain pin wrong");
   a_comparator_gate: assert property ($past(rst_n) |-> io_comparator_enable == !$past(cfg_b[7]))
      else $error("comparator enable wrong");
   a_lockout_ignored: assert property ($past(rst_n) && $past(cfg_b[7]) |-> !io_rail_lockout)
      else $error("lockout while disabled");
   a_timeout_low_time: assert property (link_reset |-> low_cnt == LINK_TIMEOUT_CYCLES)
      else $error("link reset too early");
   a_timeout_enabled: assert property (link_reset |-> $past(cfg_a[4]))
      else $error("link reset while disabled");
   a_timeout_one_pulse: assert property (link_reset |=> !link_reset)
      else $error("link reset too long");
   a_hold_pg_a: assert property ($past(rst_n) && $past(cfg_b[5]) && $past(buck_a_transition) |->
      $stable(buck_a_power_good)) else $error("buck a power good moved");
   a_hold_pg_b: assert property ($past(rst_n) && $past(cfg_b[6]) && $past(buck_b_transition) |->
      $stable(buck_b_power_good)) else $error("buck b power good moved");
   a_oc_mask_a: assert property (buck_a_oc_event |-> !($past(buck_a_transition, 2) && $past(buck_a_transition) &&
      $past(cfg_b[2:1], 2) != 2'h0 && $past(cfg_b[2:1]) != 2'h0)) else $error("buck a event not masked");
endmodule : pacm_app_config_properties
bind pacm_app_config pacm_app_config_properties #(.LINK_TIMEOUT_CYCLES(LINK_TIMEOUT_CYCLES)) pacm_app_config_properties_i (
   .mclk, .rst_n, .reg_addr, .reg_write, .reg_wdata, .scl_pin, .link_reset, .irq_request, .interrupt_output_out,
   .interrupt_output_oe, .io_comparator_enable, .io_rail_lockout, .buck_a_transition, .buck_a_power_good,
   .buck_a_oc_event, .buck_b_transition, .buck_b_power_good);

// [verification/pacm_app_config_masking_test.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module pacm_app_config_masking_test;
   localparam logic [11:0] ROWS [8] = '{12'h006, 12'h00c, 12'h095, 12'h09f, 12'h020, 12'h02c, 12'h1b3, 12'h1bf};
   logic       mclk = 1'b0;
   logic       rst_n = 1'b0;
   logic [8:0] reg_addr;
   logic       reg_write;
   logic       reg_read;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       scl_pin;
   logic       link_reset;
   logic       irq_request;
   logic       irq_out;
   logic       irq_oe;
   logic       io_uvlo_raw;
   logic       io_cmp_en;
   logic       io_lockout;
   logic       gpi_sel;
   logic [1:0] tr;
   logic [1:0] pg;
   logic [1:0] oc;
   logic [1:0] pgo;
   logic [1:0] ev;
   int         n_mismatch = 0;
   int         num_checks = 0;
   int         cycles = 0;
   int         n_lrst = 0;
   int         n_ev [2];
   pacm_host_model pacm_host_model_i (.mclk(mclk), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .scl_pin(scl_pin));
   pacm_app_config #(.LINK_TIMEOUT_CYCLES(50), .OC_LONG_CYCLES(30)) pacm_app_config_i (.mclk(mclk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .scl_pin(scl_pin), .link_reset(link_reset), .irq_request(irq_request), .interrupt_output_out(irq_out),
      .interrupt_output_oe(irq_oe), .io_uvlo_raw(io_uvlo_raw), .io_comparator_enable(io_cmp_en),
      .io_rail_lockout(io_lockout), .gpi_supply_select(gpi_sel), .buck_a_transition(tr[0]), .buck_a_pg_raw(pg[0]),
      .buck_a_oc_raw(oc[0]), .buck_a_power_good(pgo[0]), .buck_a_oc_event(ev[0]), .buck_b_transition(tr[1]),
      .buck_b_pg_raw(pg[1]), .buck_b_oc_raw(oc[1]), .buck_b_power_good(pgo[1]), .buck_b_oc_event(ev[1]));
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (link_reset === 1'b1) n_lrst++;
      if (ev[0] === 1'b1) n_ev[0]++;
      if (ev[1] === 1'b1) n_ev[1]++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   // hit at cycle d; transition is high for cycles 0..3
   task automatic oc_try(input int b, input logic [1:0] code, input int d, input logic exp);
      pacm_host_model_i.wr(9'h144, b ? {3'h0, code, 3'h0} : {5'h0, code, 1'h0});
      n_ev[b] = 0;
      for (int i = 0; i < d + 12; i++) begin
         @(negedge mclk);
         tr[b] = (i < 4);
         oc[b] = (i >= d && i < d + 3);
      end
      `CHK(n_ev[b] != 0, exp)
   endtask : oc_try
   initial begin
      logic [7:0] d;
      irq_request = 1'b0;
      io_uvlo_raw = 1'b1;
      tr = 2'h0;
      pg = 2'h3;
      oc = 2'h0;
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      pacm_host_model_i.rd(9'h143, d);
      `CHK(d, 8'h12)
      pacm_host_model_i.rd(9'h144, d);
      `CHK(d, 8'h00)
      `CHK({io_cmp_en, io_lockout}, 2'h3)
      for (int i = 0; i < 8; i++) begin
         pacm_host_model_i.wr(9'h143, ROWS[i][11:4]);
         irq_request = ROWS[i][3];
         repeat (3) @(negedge mclk);
         `CHK({irq_oe, irq_out, gpi_sel}, ROWS[i][2:0])
      end
      pacm_host_model_i.wr(9'h144, 8'ha5);
      pacm_host_model_i.wr(9'h145, 8'h5a);
      pacm_host_model_i.rd(9'h144, d);
      `CHK(d, 8'ha5)
      pacm_host_model_i.rd(9'h145, d);
      `CHK(d, 8'h00)
      `CHK({io_cmp_en, io_lockout}, 2'h0)
      io_uvlo_raw = 1'b0;
      pacm_host_model_i.scl_low(40);
      pacm_host_model_i.scl_low(45);
      `CHK(n_lrst, 0)
      pacm_host_model_i.scl_low(120);
      `CHK(n_lrst, 1)
      pacm_host_model_i.wr(9'h143, 8'h02);
      pacm_host_model_i.scl_low(120);
      `CHK(n_lrst, 1)
      pacm_host_model_i.wr(9'h144, 8'h20);
      tr = 2'h3;
      pg = 2'h0;
      repeat (6) @(negedge mclk);
      `CHK(pgo, 2'h1)
      tr = 2'h0;
      repeat (5) @(negedge mclk);
      `CHK(pgo, 2'h0)
      pg = 2'h3;
      oc_try(0, 2'h0, 1, 1'b1);
      oc_try(0, 2'h1, 1, 1'b0);
      oc_try(0, 2'h2, 2, 1'b0);
      oc_try(0, 2'h1, 194, 1'b0);
      oc_try(0, 2'h1, 219, 1'b1);
      oc_try(1, 2'h2, 904, 1'b0);
      oc_try(1, 2'h2, 1034, 1'b1);
      oc_try(1, 2'h3, 24, 1'b0);
      oc_try(1, 2'h3, 49, 1'b1);
      oc_try(1, 2'h0, 1, 1'b1);
      pacm_host_model_i.wr(9'h144, 8'h40);
      tr = 2'h3;
      pg = 2'h0;
      repeat (6) @(negedge mclk);
      `CHK(pgo, 2'h2)
      tr = 2'h0;
      for (int i = 0; i < 2; i++) begin
         io_uvlo_raw = i[0];
         repeat (5) @(negedge mclk);
         `CHK({io_lockout, pgo}, {i[0], 2'h0})
      end
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      pacm_host_model_i.rd(9'h143, d);
      `CHK(d, 8'h12)
      pacm_host_model_i.rd(9'h144, d);
      `CHK({d, io_cmp_en, io_lockout}, {8'h00, 2'h3})
      end_sim();
   end
endmodule : pacm_app_config_masking_test
